/* File: ets_sequencer.sv */
// Functional notes
// - dual capture offered only with trigger and concurrency
// - dual capture off after reset
// - dual capture forces two frames per burst
// - first exposure timed or pulse width
// - fixed gap after first exposure
// - second exposure during first readout, fixed span
// - fixed final gap before sequence completes
// - triggers ignored until final gap ends
// - fixed phases default 71, 2225, 2296 us
// - wide pixels lengthen gap, small roi shortens
// - programmable delay from trigger to exposure
// - delay counted in microseconds from trigger
// - timed mode uses programmed or automatic duration
// - pulse mode exposes while trigger held
// - pulse mode adds intrinsic exposure extension
// - exposure may overlap readout, readouts never overlap
`timescale 1ns/1ns
`default_nettype none
`include "ets_map.svh"

module ets_sequencer
   import ets_pkg::*;
#(
   parameter int CLK_HZ        = `ETS_CLK_HZ,
   parameter int WAIT1_US      = `ETS_WAIT1_US,
   parameter int EXPOSE2_US    = `ETS_EXPOSE2_US,
   parameter int WAIT2_US      = `ETS_WAIT2_US,
   parameter int READOUT_US    = `ETS_READOUT_US,
   parameter int WIDE_EXTRA_US = `ETS_WIDE_EXTRA_US,
   parameter int ROI_SAVE_US   = `ETS_ROI_SAVE_US
)
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        trigger_in,
   output logic             sensor_exposure,
   output logic             frame_readout,
   output logic             sequence_busy
);

   localparam int CYCLES_PER_US = CLK_HZ / `ETS_HZ_PER_MHZ;

   ets_tick_if tb ();

   ets_timebase #(
      .CYCLES_PER_US (CYCLES_PER_US)
   ) u_timebase (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .trigger_in (trigger_in),
      .tb         (tb.src)
   );

   logic [`ETS_CTRL_W-1:0] ctrl;
   logic [15:0]            frames_per_burst;
   logic [31:0]            programmed_exposure_duration;
   logic [31:0]            trigger_delay;
   logic [31:0]            auto_exposure_duration;
   logic [31:0]            intrinsic_exposure_extension;
   logic [7:0]             ignored_triggers;
   logic [15:0]            frames_done;

   logic                   wr_pend;
   logic [7:0]             wr_addr;
   logic                   addr_phase;

   ets_state_type          state;
   ets_state_type          next_state;
   logic [31:0]            phase_cnt;
   logic [31:0]            phase_value;
   logic                   phase_load;
   logic                   phase_done;
   logic [31:0]            ro_cnt;
   logic [31:0]            ro_value;
   logic                   ro_load;
   logic                   ro_busy;
   logic [15:0]            frames_left;
   logic                   start_burst;
   logic                   frame_taken;

   logic                   trigger_active_select;
   logic                   exposure_readout_concurrency;
   logic                   dual_available;
   logic                   dual_capture_enable;
   logic                   exposure_duration_source;
   logic                   automatic_exposure_select;
   logic [15:0]            effective_frames;
   logic [31:0]            exposure_len;
   logic [31:0]            gap1_len;
   logic                   start_ok;

   assign trigger_active_select        = ctrl[`ETS_TRIG_ACTIVE_BIT];
   assign exposure_readout_concurrency = ctrl[`ETS_CONCURRENCY_BIT];
   assign exposure_duration_source     = ctrl[`ETS_PULSE_SRC_BIT];
   assign automatic_exposure_select    = ctrl[`ETS_AUTO_SEL_BIT];

   // availability can be lost later, so the stored bit is gated as well
   assign dual_available      = trigger_active_select && exposure_readout_concurrency;
   assign dual_capture_enable = ctrl[`ETS_DUAL_BIT] && dual_available;

   always_comb
   begin
      if (dual_capture_enable)
         effective_frames = `ETS_DUAL_FRAMES;
      else if (frames_per_burst == 16'h0000)
         effective_frames = 16'h0001;
      else
         effective_frames = frames_per_burst;
   end

   assign exposure_len = automatic_exposure_select ? auto_exposure_duration
                                                   : programmed_exposure_duration;

   always_comb
   begin
      gap1_len = 32'(WAIT1_US);
      if (ctrl[`ETS_WIDE_PIX_BIT])
         gap1_len = gap1_len + 32'(WIDE_EXTRA_US);
      if (ctrl[`ETS_SMALL_ROI_BIT] && gap1_len > 32'(ROI_SAVE_US))
         gap1_len = gap1_len - 32'(ROI_SAVE_US);
   end

   // without a trigger the block free-runs; without concurrency it waits for readout
   assign start_ok = (trigger_active_select ? tb.trig_rise : 1'b1)
                     && (exposure_readout_concurrency || !ro_busy);

   // AHB-Lite slave: zero wait states, always OKAY
   assign hreadyout  = 1'b1;
   assign hresp      = 1'b0;
   assign addr_phase = hsel && htrans[1] && hready;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end
      else
      begin
         wr_pend <= addr_phase && hwrite;
         wr_addr <= haddr[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl                         <= `ETS_CTRL_RST;
         frames_per_burst             <= `ETS_FRAMES_RST;
         programmed_exposure_duration <= `ETS_EXPOSURE_RST;
         trigger_delay                <= `ETS_DELAY_RST;
         auto_exposure_duration       <= `ETS_EXPOSURE_RST;
         intrinsic_exposure_extension <= `ETS_EXTENSION_RST;
      end
      else if (wr_pend)
      begin
         case (wr_addr)
            `ETS_CTRL_OFS:
            begin
               ctrl <= hwdata[`ETS_CTRL_W-1:0];
               // the enable only sticks when it is on offer
               ctrl[`ETS_DUAL_BIT] <= hwdata[`ETS_DUAL_BIT]
                                      && hwdata[`ETS_TRIG_ACTIVE_BIT]
                                      && hwdata[`ETS_CONCURRENCY_BIT];
            end
            `ETS_FRAMES_OFS:
            begin
               if (!dual_capture_enable)
                  frames_per_burst <= hwdata[15:0];
            end
            `ETS_EXPOSURE_OFS:  programmed_exposure_duration <= hwdata;
            `ETS_DELAY_OFS:     trigger_delay                <= hwdata;
            `ETS_AUTO_OFS:      auto_exposure_duration       <= hwdata;
            `ETS_EXTENSION_OFS: intrinsic_exposure_extension <= hwdata;
            default:
            begin
            end
         endcase
      end
   end

   // read data sampled in the address phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h00000000;
      else if (addr_phase && !hwrite)
      begin
         case (haddr[7:0])
            `ETS_CTRL_OFS:
            begin
               hrdata                <= 32'(ctrl);
               hrdata[`ETS_DUAL_BIT] <= dual_capture_enable;
            end
            `ETS_FRAMES_OFS:    hrdata <= 32'(effective_frames);
            `ETS_EXPOSURE_OFS:  hrdata <= programmed_exposure_duration;
            `ETS_DELAY_OFS:     hrdata <= trigger_delay;
            `ETS_AUTO_OFS:      hrdata <= auto_exposure_duration;
            `ETS_EXTENSION_OFS: hrdata <= intrinsic_exposure_extension;
            `ETS_STATUS_OFS:
            begin
               hrdata                           <= 32'h00000000;
               hrdata[`ETS_ST_BUSY_BIT]         <= sequence_busy;
               hrdata[`ETS_ST_EXPOSE_BIT]       <= sensor_exposure;
               hrdata[`ETS_ST_READOUT_BIT]      <= ro_busy;
               hrdata[`ETS_ST_DUAL_AV_BIT]      <= dual_available;
               hrdata[`ETS_ST_STATE_LSB +: 4]   <= state;
            end
            `ETS_COUNT_OFS:     hrdata <= {ignored_triggers, 8'h00, frames_done};
            default:            hrdata <= 32'h00000000;
         endcase
      end
   end

   // sequencer
   always_comb
   begin
      next_state  = state;
      phase_load  = 1'b0;
      phase_value = 32'h00000000;
      ro_load     = 1'b0;
      ro_value    = 32'h00000000;
      start_burst = 1'b0;
      frame_taken = 1'b0;
      case (state)
         ST_IDLE:
         begin
            if (start_ok)
            begin
               start_burst = 1'b1;
               phase_load  = 1'b1;
               phase_value = trigger_delay;
               next_state  = ST_DELAY;
            end
         end
         ST_DELAY:
         begin
            if (phase_done)
            begin
               if (exposure_duration_source)
                  next_state = ST_PULSE;
               else
               begin
                  phase_load  = 1'b1;
                  phase_value = exposure_len;
                  next_state  = ST_EXPOSE;
               end
            end
         end
         ST_PULSE:
         begin
            if (!tb.trig_level)
            begin
               phase_load  = 1'b1;
               phase_value = intrinsic_exposure_extension;
               next_state  = ST_EXTEND;
            end
         end
         ST_EXPOSE, ST_EXTEND:
         begin
            if (phase_done)
            begin
               if (dual_capture_enable)
               begin
                  phase_load  = 1'b1;
                  phase_value = gap1_len;
                  next_state  = ST_GAP1;
               end
               else
                  next_state = ST_HOLD;
            end
         end
         ST_HOLD:
         begin
            // a finished exposure waits until the previous transfer is over
            if (!ro_busy)
            begin
               ro_load     = 1'b1;
               ro_value    = 32'(READOUT_US);
               frame_taken = 1'b1;
               next_state  = (frames_left > 16'h0001) ? ST_NEXT : ST_IDLE;
            end
         end
         ST_NEXT:
         begin
            if (exposure_readout_concurrency || !ro_busy)
            begin
               phase_load  = 1'b1;
               phase_value = exposure_len;
               next_state  = ST_EXPOSE;
            end
         end
         ST_GAP1:
         begin
            if (phase_done)
            begin
               phase_load  = 1'b1;
               phase_value = 32'(EXPOSE2_US);
               ro_load     = 1'b1;
               ro_value    = 32'(EXPOSE2_US);
               frame_taken = 1'b1;
               next_state  = ST_EXPOSE2;
            end
         end
         ST_EXPOSE2:
         begin
            if (phase_done)
            begin
               phase_load  = 1'b1;
               phase_value = 32'(WAIT2_US);
               ro_load     = 1'b1;
               ro_value    = 32'(WAIT2_US);
               frame_taken = 1'b1;
               next_state  = ST_GAP2;
            end
         end
         ST_GAP2:
         begin
            if (phase_done)
               next_state = ST_IDLE;
         end
         default:
            next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         state <= ST_IDLE;
      else
         state <= next_state;
   end

   // every phase starts on a fresh microsecond boundary
   assign tb.restart = phase_load;
   assign phase_done = (phase_cnt == 32'h00000000)
                       || (phase_cnt == 32'h00000001 && tb.tick);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         phase_cnt <= 32'h00000000;
      else if (phase_load)
         phase_cnt <= phase_value;
      else if (tb.tick && phase_cnt != 32'h00000000)
         phase_cnt <= phase_cnt - 32'h00000001;
   end

   // readout runs on the free microsecond grid, so a restart can stretch it by < 1 us
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         ro_cnt <= 32'h00000000;
      else if (ro_load)
         ro_cnt <= ro_value;
      else if (tb.tick && ro_cnt != 32'h00000000)
         ro_cnt <= ro_cnt - 32'h00000001;
   end

   assign ro_busy = (ro_cnt != 32'h00000000);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         frames_left <= 16'h0000;
      else if (start_burst)
         frames_left <= effective_frames;
      else if (frame_taken && frames_left != 16'h0000)
         frames_left <= frames_left - 16'h0001;
   end

   // triggers outside idle, or while readout blocks, are dropped and counted
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         ignored_triggers <= 8'h00;
      else if (trigger_active_select && tb.trig_rise && !(state == ST_IDLE && start_ok))
         ignored_triggers <= ignored_triggers + 8'h01;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         frames_done <= 16'h0000;
      else if (frame_taken)
         frames_done <= frames_done + 16'h0001;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sensor_exposure <= 1'b0;
         frame_readout   <= 1'b0;
         sequence_busy   <= 1'b0;
      end
      else
      begin
         sensor_exposure <= (next_state == ST_EXPOSE) || (next_state == ST_PULSE)
                            || (next_state == ST_EXTEND) || (next_state == ST_EXPOSE2);
         frame_readout   <= ro_load || (ro_busy && !(tb.tick && ro_cnt == 32'h00000001));
         sequence_busy   <= (next_state != ST_IDLE);
      end
   end

endmodule // ets_sequencer

`default_nettype wire

/* File: ets_map.svh */
`ifndef ETS_MAP_SVH
`define ETS_MAP_SVH

// time base
`define ETS_CLK_HZ          10000000
`define ETS_HZ_PER_MHZ      1000000

// fixed dual-capture phases, microseconds
`define ETS_WAIT1_US        71
`define ETS_EXPOSE2_US      2225
`define ETS_WAIT2_US        2296
// single-frame readout and gap adjustments, microseconds
`define ETS_READOUT_US      2225
`define ETS_WIDE_EXTRA_US   18
`define ETS_ROI_SAVE_US     0

// register byte offsets
`define ETS_CTRL_OFS        8'h00
`define ETS_FRAMES_OFS      8'h04
`define ETS_EXPOSURE_OFS    8'h08
`define ETS_DELAY_OFS       8'h0c
`define ETS_AUTO_OFS        8'h10
`define ETS_EXTENSION_OFS   8'h14
`define ETS_STATUS_OFS      8'h18
`define ETS_COUNT_OFS       8'h1c

// control fields
`define ETS_TRIG_ACTIVE_BIT 0
`define ETS_CONCURRENCY_BIT 1
`define ETS_DUAL_BIT        2
`define ETS_PULSE_SRC_BIT   3
`define ETS_AUTO_SEL_BIT    4
`define ETS_WIDE_PIX_BIT    5
`define ETS_SMALL_ROI_BIT   6
`define ETS_CTRL_W          7

// status fields
`define ETS_ST_BUSY_BIT     0
`define ETS_ST_EXPOSE_BIT   1
`define ETS_ST_READOUT_BIT  2
`define ETS_ST_DUAL_AV_BIT  3
`define ETS_ST_STATE_LSB    8

// reset values and dual-capture frame count
`define ETS_CTRL_RST        7'h00
`define ETS_FRAMES_RST      16'h0001
`define ETS_EXPOSURE_RST    32'h000003e8
`define ETS_DELAY_RST       32'h00000000
`define ETS_EXTENSION_RST   32'h00000000
`define ETS_DUAL_FRAMES     16'h0002

`endif

/* File: ets_pkg.sv */
`default_nettype none

package ets_pkg;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_DELAY,
      ST_EXPOSE,
      ST_PULSE,
      ST_EXTEND,
      ST_HOLD,
      ST_NEXT,
      ST_GAP1,
      ST_EXPOSE2,
      ST_GAP2
   } ets_state_type;

endpackage : ets_pkg

`default_nettype wire

/* File: ets_tick_if.sv */
`timescale 1ns/1ns
`default_nettype none

interface ets_tick_if;
   logic restart;
   logic tick;
   logic trig_level;
   logic trig_rise;

   modport src (input restart, output tick, output trig_level, output trig_rise);
   modport snk (output restart, input tick, input trig_level, input trig_rise);
endinterface : ets_tick_if

`default_nettype wire

/* File: ets_timebase.sv */
`timescale 1ns/1ns
`default_nettype none
`include "ets_map.svh"

module ets_timebase
   import ets_pkg::*;
#(
   parameter int CYCLES_PER_US = `ETS_CLK_HZ / `ETS_HZ_PER_MHZ
)
(
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic trigger_in,
   ets_tick_if.src   tb
);

   localparam int PW = $clog2(CYCLES_PER_US + 1);

   logic [PW-1:0] prescale;
   logic          sync1;
   logic          sync2;
   logic          sync3;
   logic          level;

   // restart aligns the microsecond grid to the start of a phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         prescale <= '0;
      else if (tb.restart || prescale == PW'(CYCLES_PER_US - 1))
         prescale <= '0;
      else
         prescale <= prescale + 1'b1;
   end

   // not gated by restart: phase ends feed restart, gating would loop
   assign tb.tick = (prescale == PW'(CYCLES_PER_US - 1));

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         sync3 <= 1'b0;
      end
      else
      begin
         sync1 <= trigger_in;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // a change counts only once stages two and three agree
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         level <= 1'b0;
      else if (sync2 == sync3)
         level <= sync3;
   end

   assign tb.trig_level = level;
   assign tb.trig_rise  = (sync2 == sync3) && sync3 && !level;

endmodule // ets_timebase

`default_nettype wire

/* File: ets_sequencer_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module ets_sequencer_asserts
#(
   parameter int CLK_HZ        = 10000000,
   parameter int WAIT1_US      = 71,
   parameter int EXPOSE2_US    = 2225,
   parameter int WAIT2_US      = 2296,
   parameter int WIDE_EXTRA_US = 18,
   parameter int ROI_SAVE_US   = 0
)
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        sensor_exposure,
   input wire logic        frame_readout,
   input wire logic        sequence_busy
);
   localparam int C = CLK_HZ / 1000000;
   // slack of a few cycles: every phase adds a load cycle
   localparam int G1_LO = (WAIT1_US - ROI_SAVE_US) * C - 1, G1_HI = (WAIT1_US + WIDE_EXTRA_US) * C + 4;
   localparam int X2_LO = EXPOSE2_US * C - 1, X2_HI = EXPOSE2_US * C + 4;
   localparam int G2_LO = WAIT2_US * C - 1, G2_HI = WAIT2_US * C + 4;
   logic in_dual;
   int   run_len;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         run_len <= 0;
         in_dual <= 1'b0;
      end
      else
      begin
         run_len <= $changed(sensor_exposure) ? 1 : run_len + 1;
         if ($rose(sensor_exposure) && $rose(frame_readout))
            in_dual <= 1'b1;
         else if (!sequence_busy)
            in_dual <= 1'b0;
      end
   end
   sequence s_exp2_start;
      $rose(sensor_exposure) && $rose(frame_readout);
   endsequence
   sequence s_tail;
      in_dual && !sensor_exposure;
   endsequence
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not zero-wait okay");
   a_rdata_holds: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
      else $error("read data changed without a read");
   a_reset_quiet: assert property ($rose(hresetn) |-> !sensor_exposure && !frame_readout)
      else $error("activity right after reset");
   a_expose_in_busy: assert property (sensor_exposure |-> sequence_busy)
      else $error("exposure while idle");
   a_delay_first: assert property ($rose(sequence_busy) |-> !sensor_exposure)
      else $error("exposure without delay phase");
   a_gap1_span: assert property (s_exp2_start |-> run_len inside {[G1_LO:G1_HI]})
      else $error("first gap length wrong");
   a_exp2_span: assert property (in_dual && $fell(sensor_exposure) |-> run_len inside {[X2_LO:X2_HI]})
      else $error("second exposure length wrong");
   a_tail_readout: assert property (s_tail |-> frame_readout || !sequence_busy)
      else $error("readout low in final gap");
   a_tail_quiet: assert property (s_tail |=> !sensor_exposure)
      else $error("exposure started in final gap");
   a_gap2_span: assert property (in_dual && $fell(sequence_busy) |-> run_len inside {[G2_LO:G2_HI]})
      else $error("final gap length wrong");
endmodule // ets_sequencer_asserts
bind ets_sequencer ets_sequencer_asserts #(.CLK_HZ(CLK_HZ), .WAIT1_US(WAIT1_US),
   .EXPOSE2_US(EXPOSE2_US), .WAIT2_US(WAIT2_US), .WIDE_EXTRA_US(WIDE_EXTRA_US),
   .ROI_SAVE_US(ROI_SAVE_US)) u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .sensor_exposure(sensor_exposure),
   .frame_readout(frame_readout), .sequence_busy(sequence_busy));
`default_nettype wire

/* File: ets_trigger_src.sv */
`timescale 1ns/1ns
`default_nettype none
module ets_trigger_src
(
   input  wire logic hclk,
   output logic      trigger_in
);
   initial trigger_in = 1'b0;
   // hardware pin only, no software trigger path
   task automatic pulse(input int n);
      @(posedge hclk);
      trigger_in <= 1'b1;
      repeat (n) @(posedge hclk);
      trigger_in <= 1'b0;
   endtask
endmodule // ets_trigger_src
`default_nettype wire

/* File: exposure_trigger_sequencer_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) \
   begin n_tests++; if ((g) !== (e)) begin n_errors++; \
   $display("mismatch at %0t: got %0h expected %0h", $time, g, e); end end
module exposure_trigger_sequencer_tb;
   localparam int C  = 10;
   localparam int W1 = 3;
   localparam int X2 = 5;
   localparam int W2 = 7;
   localparam int WX = 2;
   localparam int RS = 1;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hready;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        trigger_in;
   logic        sensor_exposure;
   logic        frame_readout;
   logic        sequence_busy;
   logic [31:0] mreg [8];
   int          n_errors = 0;
   int          n_tests  = 0;
   int          cyc      = 0;
   int          seed     = 99212;
   logic [6:0]  modes [5] = '{7'h07, 7'h27, 7'h47, 7'h17, 7'h0f};
   logic [7:0]  addrs [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h40};
   assign hready = hreadyout;
   ets_sequencer #(.WAIT1_US(W1), .EXPOSE2_US(X2), .WAIT2_US(W2), .READOUT_US(5),
      .WIDE_EXTRA_US(WX), .ROI_SAVE_US(RS)) dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .trigger_in(trigger_in), .sensor_exposure(sensor_exposure),
      .frame_readout(frame_readout), .sequence_busy(sequence_busy));
   ets_trigger_src trig (.hclk(hclk), .trigger_in(trigger_in));
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask
   function automatic logic [31:0] mread(input logic [7:0] a);
      logic dual;
      dual = mreg[0][2] & mreg[0][1] & mreg[0][0];
      case (a)
         8'h00: mread = {25'h0, mreg[0][6:3], dual, mreg[0][1:0]};
         8'h04: mread = dual ? 32'h2 : mreg[1];
         8'h08, 8'h0c, 8'h10, 8'h14: mread = mreg[a[4:2]];
         default: mread = 32'h0;
      endcase
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        dual;
      dual = mreg[0][2] & mreg[0][1] & mreg[0][0];
      bus(1'b1, a, d, q);
      if (a == 8'h00)
         mreg[0] = {25'h0, d[6:3], d[2] & d[1] & d[0], d[1:0]};
      else if (a != 8'h04 || !dual)
         mreg[a[4:2]] = (a == 8'h04) ? {16'h0, d[15:0]} : d;
   endtask
   task automatic rd_chk(input logic [7:0] a);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      `CHK(q, mread(a))
   endtask
   task automatic cnt_until(input logic busy, input logic v, output int n);
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while ((busy ? sequence_busy : sensor_exposure) !== v);
   endtask
   function automatic logic inr(input int v, input int lo, input int hi);
      return v >= lo && v <= hi;
   endfunction
   task automatic dual_run(input logic [6:0] ctl);
      int          n [5];
      int          d;
      int          e;
      int          g;
      int          p;
      logic [31:0] c0;
      logic [31:0] c1;
      d = ctl[3] ? 0 : 1 + {$random(seed)} % 3;
      e = 1 + {$random(seed)} % 4;
      p = 2 + {$random(seed)} % 3;
      g = W1 + (ctl[5] ? WX : 0) - (ctl[6] ? RS : 0);
      wr(8'h0c, d);
      wr(8'h08, e);
      wr(8'h10, e + 1);
      wr(8'h14, 32'h1);
      wr(8'h00, {25'h0, ctl});
      bus(1'b0, 8'h1c, 32'h0, c0);
      e = ctl[3] ? p + 1 : (ctl[4] ? e + 1 : e);
      fork
         begin
            trig.pulse(p * C);
            repeat ((d + e + g + 3) * C) @(posedge hclk);
            trig.pulse(C);
         end
         begin
            cnt_until(1'b0, 1'b1, n[0]);
            cnt_until(1'b0, 1'b0, n[1]);
            cnt_until(1'b0, 1'b1, n[2]);
            cnt_until(1'b0, 1'b0, n[3]);
            cnt_until(1'b1, 1'b0, n[4]);
         end
      join
      `CHK(inr(n[0], d * C + 3, d * C + 10), 1'b1)
      `CHK(inr(n[1], e * C - (ctl[3] ? 8 : 1), e * C + 4), 1'b1)
      `CHK(inr(n[2], g * C - 1, g * C + 4), 1'b1)
      `CHK(inr(n[3], X2 * C - 1, X2 * C + 4), 1'b1)
      `CHK(inr(n[4], W2 * C - 1, W2 * C + 4), 1'b1)
      repeat (20) @(posedge hclk);
      `CHK(sequence_busy, 1'b0)
      bus(1'b0, 8'h1c, 32'h0, c1);
      `CHK(c1[31:24], c0[31:24] + 8'h1)
      `CHK(c1[15:0], c0[15:0] + 16'h2)
      $display("test mode %0h done", ctl);
   endtask
   // two-frame burst without dual capture; readout is 5 us in this bench
   task automatic burst_run(input logic [6:0] ctl);
      int          n [2];
      logic [31:0] c0;
      logic [31:0] c1;
      wr(8'h00, {25'h0, ctl});
      wr(8'h04, 32'h2);
      rd_chk(8'h04);
      bus(1'b0, 8'h1c, 32'h0, c0);
      fork
         trig.pulse(C);
         begin
            cnt_until(1'b0, 1'b1, n[0]);
            cnt_until(1'b0, 1'b0, n[0]);
            cnt_until(1'b0, 1'b1, n[1]);
            cnt_until(1'b1, 1'b0, n[1]);
         end
      join
      `CHK(inr(n[0], mreg[2] * C - 1, mreg[2] * C + 4), 1'b1)
      bus(1'b0, 8'h1c, 32'h0, c1);
      `CHK(c1[15:0], c0[15:0] + 16'h2)
      $display("test burst mode %0h done", ctl);
   endtask
   initial
   begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   // cut a hang short; the first free-run frame alone takes about 10000 cycles
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         n_errors++;
         tally_and_finish;
      end
   end
   initial
   begin
      int n;
      hresetn = 1'b0;
      hsel    = 1'b0;
      haddr   = 32'h0;
      htrans  = 2'b00;
      hwrite  = 1'b0;
      hsize   = 3'b010;
      hwdata  = 32'h0;
      mreg    = '{32'h0, 32'h1, 32'h3e8, 32'h0, 32'h3e8, 32'h0, 32'h0, 32'h0};
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (addrs[i]) rd_chk(addrs[i]);
      wr(8'h00, 32'h04);
      rd_chk(8'h00);
      wr(8'h00, 32'h05);
      rd_chk(8'h00);
      wr(8'h00, 32'h03);
      wr(8'h04, 32'h3);
      rd_chk(8'h04);
      wr(8'h00, 32'h07);
      wr(8'h04, 32'h5);
      rd_chk(8'h00);
      rd_chk(8'h04);
      $display("test register access done");
      cnt_until(1'b1, 1'b0, n);
      foreach (modes[i]) dual_run(modes[i]);
      burst_run(7'h01);
      burst_run(7'h03);
      tally_and_finish;
   end
endmodule // exposure_trigger_sequencer_tb
`default_nettype wire
